// File: src/ssc_strobe_ctl.sv
// Slot-bus command strobe control: bus ownership, strobe pins, CPU cycles
// with 16-to-8 conversion. Assumes DMA strobes arrive from internal DMA logic.
`timescale 1ns/1ps
module ssc_strobe_ctl
    import ssc_pkg::*;
#(
    parameter logic [ssc_pkg::SSC_CNT_W-1:0] CMD_CYCLES = ssc_pkg::SSC_CMD_CYCLES,
    parameter logic [ssc_pkg::SSC_CNT_W-1:0] RECOV_CYCLES = ssc_pkg::SSC_RECOV_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Arbitration
    input wire logic hold_grant,
    input wire logic masterReqN,
    output logic dmaHoldOff,
    // Internal DMA strobes
    input wire logic [ssc_pkg::SSC_NUM_STB-1:0] dmaStrobeN,
    // CPU request and answer
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic cpuIo,
    input wire logic cpuWide,
    input wire logic [ssc_pkg::SSC_DATA_W-1:0] cpuWdata,
    output logic cpuReady,
    output logic cpuDone,
    output logic cpuConverted,
    output logic [ssc_pkg::SSC_DATA_W-1:0] cpuRdata,
    // Wide selects from slot adapters
    input wire logic wide_mem_select_n,
    input wire logic wide_io_select_n,
    // Strobe pins
    input wire logic ioReadStrobeNIn,
    output logic ioReadStrobeNOut,
    output logic ioReadStrobeOeN,
    input wire logic ioWriteStrobeNIn,
    output logic ioWriteStrobeNOut,
    output logic ioWriteStrobeOeN,
    input wire logic memReadStrobeNIn,
    output logic memReadStrobeNOut,
    output logic memReadStrobeOeN,
    input wire logic memWriteStrobeNIn,
    output logic memWriteStrobeNOut,
    output logic memWriteStrobeOeN,
    output logic [ssc_pkg::SSC_NUM_STB-1:0] busStrobeSeenN,
    // Slot data and byte select
    input wire logic [ssc_pkg::SSC_DATA_W-1:0] slotDataIn,
    output logic [ssc_pkg::SSC_DATA_W-1:0] slotDataOut,
    output logic slotDataOeN,
    output logic slotAddr0
);
    import ssc_pkg::*;

    // ****************************************************
    // Ownership decode
    // ****************************************************
    function automatic ssc_owner_t ownerOf(input logic hg, input logic mreqN);
        ssc_owner_t o;
        if (!hg)
        begin
            o = SSC_OWN_CPU;
        end
        else if (mreqN)
        begin
            o = SSC_OWN_DMA;
        end
        else
        begin
            o = SSC_OWN_MASTER;
        end
        return o;
    endfunction

    ssc_owner_t owner;
    assign owner = ownerOf(hold_grant, masterReqN);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        ssc_state_t st;
        logic [SSC_CNT_W-1:0] cnt;
        logic write;
        logic io;
        logic wide;
        logic conv;
        logic hiPhase;
        logic [SSC_DATA_W-1:0] wdata;
        logic [SSC_NUM_STB-1:0] cpuStbN;
        logic done;
        logic ready;
        logic holdOff;
        logic addr0;
        logic [SSC_DATA_W-1:0] dOut;
        logic dOeN;
    } ssc_ctl_t;

    ssc_ctl_t s_r;
    ssc_ctl_t s_nxt;
    logic captLo;
    logic captHi;
    logic captWord;
    logic wideSelHigh;
    logic [SSC_NUM_STB-1:0] stbOut;
    logic [SSC_NUM_STB-1:0] stbOeN;
    logic [SSC_NUM_STB-1:0] stbIn;

    assign wideSelHigh = s_r.io ? wide_io_select_n : wide_mem_select_n;

    // ****************************************************
    // CPU cycle sequencer
    // ****************************************************
    always_comb
    begin
        s_nxt = s_r;
        captLo = 1'b0;
        captHi = 1'b0;
        captWord = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.holdOff = (owner == SSC_OWN_MASTER);
        case (s_r.st)
            SSC_ST_IDLE:
            begin
                // Requests are taken only while the CPU owns the bus
                if (cpuReq && s_r.ready && owner == SSC_OWN_CPU)
                begin
                    s_nxt.st = SSC_ST_CMD;
                    s_nxt.cnt = CMD_CYCLES;
                    s_nxt.write = cpuWrite;
                    s_nxt.io = cpuIo;
                    s_nxt.wide = cpuWide;
                    s_nxt.conv = 1'b0;
                    s_nxt.hiPhase = 1'b0;
                    s_nxt.wdata = cpuWdata;
                    s_nxt.addr0 = 1'b0;
                end
            end
            SSC_ST_CMD:
            begin
                // Select is sampled in the first strobe cycle
                if (s_r.cnt == CMD_CYCLES && !s_r.hiPhase)
                begin
                    s_nxt.conv = s_r.wide && wideSelHigh;
                end
                s_nxt.cnt = s_r.cnt - 1'b1;
                if (s_r.cnt == 1)
                begin
                    if (s_r.conv && !s_r.hiPhase)
                    begin
                        captLo = !s_r.write;
                        s_nxt.st = SSC_ST_RECOV;
                        s_nxt.cnt = RECOV_CYCLES;
                    end
                    else
                    begin
                        captHi = !s_r.write && s_r.hiPhase;
                        captWord = !s_r.write && !s_r.hiPhase && s_r.wide;
                        captLo = !s_r.write && !s_r.hiPhase && !s_r.wide;
                        s_nxt.st = SSC_ST_IDLE;
                        s_nxt.done = 1'b1;
                        s_nxt.addr0 = 1'b0;
                    end
                end
            end
            SSC_ST_RECOV:
            begin
                s_nxt.cnt = s_r.cnt - 1'b1;
                if (s_r.cnt == 1)
                begin
                    // Second byte: odd address, high byte on the low lane
                    s_nxt.st = SSC_ST_CMD;
                    s_nxt.cnt = CMD_CYCLES;
                    s_nxt.hiPhase = 1'b1;
                    s_nxt.addr0 = 1'b1;
                end
            end
            default:
            begin
                s_nxt.st = SSC_ST_IDLE;
            end
        endcase
        s_nxt.ready = (s_nxt.st == SSC_ST_IDLE);
        s_nxt.cpuStbN = SSC_STB_IDLE;
        if (s_nxt.st == SSC_ST_CMD)
        begin
            s_nxt.cpuStbN[SSC_STB_IOR] = !(s_nxt.io && !s_nxt.write);
            s_nxt.cpuStbN[SSC_STB_IOW] = !(s_nxt.io && s_nxt.write);
            s_nxt.cpuStbN[SSC_STB_MEM_READ_STROBE_N] = !(!s_nxt.io && !s_nxt.write);
            s_nxt.cpuStbN[SSC_STB_MEM_WRITE_STROBE_N] = !(!s_nxt.io && s_nxt.write);
        end
        s_nxt.dOeN = !(s_nxt.st != SSC_ST_IDLE && s_nxt.write && owner == SSC_OWN_CPU);
        s_nxt.dOut = s_nxt.hiPhase ? {s_nxt.wdata[15:8], s_nxt.wdata[15:8]} : s_nxt.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '{st: SSC_ST_IDLE, cnt: '0, cpuStbN: SSC_STB_IDLE, dOeN: 1'b1,
                     dOut: '0, wdata: '0, default: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************
    // Strobe pins
    // ****************************************************
    // CPU strobes pass the mux one cycle after they are computed
    assign stbIn = {memWriteStrobeNIn, memReadStrobeNIn, ioWriteStrobeNIn, ioReadStrobeNIn};

    genvar gi;
    generate
        for (gi = 0; gi < SSC_NUM_STB; gi++)
        begin : g_stb
            ssc_strobe_mux u_mux (
                .clk(clk),
                .rst(rst),
                .owner(owner),
                .cpuStbN(s_nxt.cpuStbN[gi]),
                .dmaStbN(dmaStrobeN[gi]),
                .pinIn(stbIn[gi]),
                .pinOut(stbOut[gi]),
                .pinOeN(stbOeN[gi]),
                .seenN(busStrobeSeenN[gi])
            );
        end
    endgenerate

    ssc_byte_asm u_asm (
        .clk(clk),
        .rst(rst),
        .captLo(captLo),
        .captHi(captHi),
        .captWord(captWord),
        .dataIn(slotDataIn),
        .word(cpuRdata)
    );

    assign ioReadStrobeNOut = stbOut[SSC_STB_IOR];
    assign ioReadStrobeOeN = stbOeN[SSC_STB_IOR];
    assign ioWriteStrobeNOut = stbOut[SSC_STB_IOW];
    assign ioWriteStrobeOeN = stbOeN[SSC_STB_IOW];
    assign memReadStrobeNOut = stbOut[SSC_STB_MEM_READ_STROBE_N];
    assign memReadStrobeOeN = stbOeN[SSC_STB_MEM_READ_STROBE_N];
    assign memWriteStrobeNOut = stbOut[SSC_STB_MEM_WRITE_STROBE_N];
    assign memWriteStrobeOeN = stbOeN[SSC_STB_MEM_WRITE_STROBE_N];
    assign dmaHoldOff = s_r.holdOff;
    assign cpuReady = s_r.ready;
    assign cpuDone = s_r.done;
    assign cpuConverted = s_r.conv;
    assign slotAddr0 = s_r.addr0;
    assign slotDataOut = s_r.dOut;
    assign slotDataOeN = s_r.dOeN;

    // ****************************************************
    // Checks
    // ****************************************************
    ior_input_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && !masterReqN |=> ioReadStrobeOeN)
        else $error("I/O read driven while master owns bus");
    ior_cpu_a: assert property (@(posedge clk) disable iff (rst)
        !hold_grant |=> !ioReadStrobeOeN && ioReadStrobeNOut == $past(s_nxt.cpuStbN[0]))
        else $error("I/O read not from CPU cycle logic");
    ior_dma_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && masterReqN |=> ioReadStrobeNOut == $past(dmaStrobeN[0]))
        else $error("I/O read not from DMA");
    iow_input_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && !masterReqN |=> ioWriteStrobeOeN && ioWriteStrobeNOut)
        else $error("I/O write driven while master owns bus");
    iow_cpu_a: assert property (@(posedge clk) disable iff (rst)
        !hold_grant |=> !ioWriteStrobeOeN && ioWriteStrobeNOut == $past(s_nxt.cpuStbN[1]))
        else $error("I/O write not from CPU cycle logic");
    iow_dma_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && masterReqN |=> !ioWriteStrobeOeN && ioWriteStrobeNOut == $past(dmaStrobeN[1]))
        else $error("I/O write not from DMA");
    mem_read_strobe_n_input_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && !masterReqN |=> memReadStrobeOeN && busStrobeSeenN[2] == $past(memReadStrobeNIn))
        else $error("Memory read driven while master owns bus");
    mem_read_strobe_n_cpu_a: assert property (@(posedge clk) disable iff (rst)
        !hold_grant |=> !memReadStrobeOeN && memReadStrobeNOut == $past(s_nxt.cpuStbN[2]))
        else $error("Memory read not from CPU cycle logic");
    mem_read_strobe_n_dma_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && masterReqN |=> !memReadStrobeOeN && memReadStrobeNOut == $past(dmaStrobeN[2]))
        else $error("Memory read not from DMA");
    mem_write_strobe_n_input_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && !masterReqN |=> memWriteStrobeOeN)
        else $error("Memory write driven while master owns bus");
    mem_write_strobe_n_dma_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && masterReqN |=> !memWriteStrobeOeN && memWriteStrobeNOut == $past(dmaStrobeN[3]))
        else $error("Memory write not from DMA");
    mem_write_strobe_n_cpu_a: assert property (@(posedge clk) disable iff (rst)
        !hold_grant |=> !memWriteStrobeOeN && memWriteStrobeNOut == $past(s_nxt.cpuStbN[3]))
        else $error("Memory write not from CPU cycle logic");
    master_owns_a: assert property (@(posedge clk) disable iff (rst)
        hold_grant && !masterReqN |=> dmaHoldOff && (&stbOeN))
        else $error("DMA not held off for master");
    conv_start_a: assert property (@(posedge clk) disable iff (rst)
        s_r.st == SSC_ST_CMD && s_r.cnt == CMD_CYCLES && !s_r.hiPhase && s_r.wide
        && !s_r.io && wide_mem_select_n |=> cpuConverted)
        else $error("Wide memory cycle not converted");
    conv_io_a: assert property (@(posedge clk) disable iff (rst)
        s_r.st == SSC_ST_CMD && s_r.cnt == CMD_CYCLES && !s_r.hiPhase && s_r.wide
        && s_r.io && !wide_io_select_n |=> !cpuConverted)
        else $error("Wide I/O cycle converted with select low");
    io_conv_a: assert property (@(posedge clk) disable iff (rst)
        s_r.st == SSC_ST_CMD && s_r.cnt == CMD_CYCLES && !s_r.hiPhase && s_r.wide
        && s_r.io && wide_io_select_n |=> cpuConverted)
        else $error("Wide I/O cycle not converted");
    conv_order_a: assert property (@(posedge clk) disable iff (rst)
        s_r.st == SSC_ST_RECOV && $past(s_r.st) == SSC_ST_CMD |-> !slotAddr0
        ##[1:40] slotAddr0 && s_r.st == SSC_ST_CMD)
        else $error("Second byte of conversion not at odd address");
endmodule

// File: shared/ssc_pkg.sv
// Shared constants for the slot-bus strobe control block.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package ssc_pkg;

    // ****************************************************
    // Clock and timing
    // ****************************************************
    localparam int SSC_CLK_PERIOD_PS = 8000;
    // Length of one slot command strobe
    localparam int SSC_CMD_NS = 250;
    // Strobe-high recovery between the two halves of a conversion
    localparam int SSC_RECOV_NS = 125;
    localparam int SSC_CNT_W = 6;
    // Least times, rounded up to whole cycles
    localparam logic [SSC_CNT_W-1:0] SSC_CMD_CYCLES =
        SSC_CNT_W'((SSC_CMD_NS * 1000 + SSC_CLK_PERIOD_PS - 1) / SSC_CLK_PERIOD_PS);
    localparam logic [SSC_CNT_W-1:0] SSC_RECOV_CYCLES =
        SSC_CNT_W'((SSC_RECOV_NS * 1000 + SSC_CLK_PERIOD_PS - 1) / SSC_CLK_PERIOD_PS);

    // ****************************************************
    // Strobe lanes
    // ****************************************************
    localparam int SSC_NUM_STB = 4;
    localparam int SSC_STB_IOR = 0;
    localparam int SSC_STB_IOW = 1;
    localparam int SSC_STB_MEM_READ_STROBE_N = 2;
    localparam int SSC_STB_MEM_WRITE_STROBE_N = 3;
    localparam logic [SSC_NUM_STB-1:0] SSC_STB_IDLE = 4'hF;

    // ****************************************************
    // Data layout
    // ****************************************************
    localparam int SSC_DATA_W = 16;
    localparam int SSC_BYTE_W = 8;

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {
        SSC_OWN_CPU = 2'b00,
        SSC_OWN_DMA = 2'b01,
        SSC_OWN_MASTER = 2'b10
    } ssc_owner_t;

    typedef enum logic [1:0] {
        SSC_ST_IDLE = 2'b00,
        SSC_ST_CMD = 2'b01,
        SSC_ST_RECOV = 2'b10
    } ssc_state_t;

endpackage

// File: src/ssc_strobe_mux.sv
// Direction and source selection for one slot command strobe pin.
// Assumes the owner code is decoded by the caller every cycle.
`timescale 1ns/1ps
module ssc_strobe_mux
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sources
    input wire ssc_pkg::ssc_owner_t owner,
    input wire logic cpuStbN,
    input wire logic dmaStbN,
    // Pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOeN,
    // Level seen on the bus
    output logic seenN
);
    typedef struct packed {
        logic outN;
        logic oeN;
        logic seenN;
    } ssc_mux_t;

    ssc_mux_t s_r;
    ssc_mux_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        case (owner)
            SSC_OWN_CPU:
            begin
                s_nxt.outN = cpuStbN;
                s_nxt.oeN = 1'b0;
            end
            SSC_OWN_DMA:
            begin
                s_nxt.outN = dmaStbN;
                s_nxt.oeN = 1'b0;
            end
            default:
            begin
                // Master drives; keep our driver parked high
                s_nxt.outN = 1'b1;
                s_nxt.oeN = 1'b1;
            end
        endcase
        s_nxt.seenN = (owner == SSC_OWN_MASTER) ? pinIn : s_nxt.outN;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Released during reset to avoid fighting a master
            s_r <= '{outN: 1'b1, oeN: 1'b1, seenN: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign pinOut = s_r.outN;
    assign pinOeN = s_r.oeN;
    assign seenN = s_r.seenN;
endmodule

// File: src/ssc_byte_asm.sv
// Read data assembly for full-width and converted CPU accesses.
// Assumes the high byte of a converted access arrives on the low lane.
`timescale 1ns/1ps
module ssc_byte_asm
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Capture controls
    input wire logic captLo,
    input wire logic captHi,
    input wire logic captWord,
    input wire logic [ssc_pkg::SSC_DATA_W-1:0] dataIn,
    // Assembled word
    output logic [ssc_pkg::SSC_DATA_W-1:0] word
);
    typedef struct packed {
        logic [SSC_BYTE_W-1:0] hi;
        logic [SSC_BYTE_W-1:0] lo;
    } ssc_asm_t;

    ssc_asm_t s_r;
    ssc_asm_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (captWord)
        begin
            s_nxt = dataIn;
        end
        else if (captLo)
        begin
            s_nxt.lo = dataIn[SSC_BYTE_W-1:0];
            s_nxt.hi = '0;
        end
        else if (captHi)
        begin
            s_nxt.hi = dataIn[SSC_BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign word = s_r;
endmodule

// File: tb/ssc_slot_model.sv
// Slot side model: strobe pull-ups, adapter wide selects, read data lines.
// Assumes the bench plays the external master through mstStbN and mstDrv.
`timescale 1ns/1ps
module ssc_slot_model
    import ssc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device pin drive
    input wire logic [ssc_pkg::SSC_NUM_STB-1:0] stbOutN,
    input wire logic [ssc_pkg::SSC_NUM_STB-1:0] stbOeN,
    input wire logic addr0,
    // External master
    input wire logic [ssc_pkg::SSC_NUM_STB-1:0] mstStbN,
    input wire logic mstDrv,
    // Card setup
    input wire logic memWide,
    input wire logic ioWide,
    // Lines back to the device
    output logic [ssc_pkg::SSC_NUM_STB-1:0] pinN,
    output logic wideMemSelN,
    output logic wideIoSelN,
    output logic [ssc_pkg::SSC_DATA_W-1:0] dataIn
);
    localparam logic [7:0] LO_BYTE = 8'hA5;
    localparam logic [7:0] HI_BYTE = 8'h3C;
    logic tog_r = 1'b0;

    always_ff @(posedge clk)
    begin
        tog_r <= ~tog_r;
    end

    // ****************************************************
    // Strobe wires
    // ****************************************************
    // Pull-ups hold a released strobe high
    always_comb
    begin
        for (int i = 0; i < SSC_NUM_STB; i++)
        begin
            pinN[i] = !stbOeN[i] ? stbOutN[i] : (mstDrv ? mstStbN[i] : 1'b1);
        end
    end

    // ****************************************************
    // Cards
    // ****************************************************
    assign wideMemSelN = ~memWide;
    assign wideIoSelN = ~ioWide;
    // No pull on data: a toggling pattern stands for floating lines
    assign dataIn = (!pinN[SSC_STB_IOR] || !pinN[SSC_STB_MEM_READ_STROBE_N])
        ? {HI_BYTE, addr0 ? HI_BYTE : LO_BYTE} : {16{tog_r}};
endmodule

// File: tb/ssc_strobe_ctl_tb_top.sv
// Bench for the slot strobe control: ownership decode and CPU cycles.
// Assumes the slot model supplies pull-ups, wide selects and read data.
`timescale 1ns/1ps
module ssc_strobe_ctl_tb_top import ssc_pkg::*;;
    localparam int CMD = 2;
    localparam int RECOV = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hold_grant = 1'b0;
    logic masterReqN = 1'b1;
    logic [3:0] dmaStrobeN = 4'hF;
    logic cpuReq = 1'b0;
    logic cpuWrite = 1'b0;
    logic cpuIo = 1'b0;
    logic cpuWide = 1'b0;
    logic [15:0] cpuWdata = 16'hC396;
    logic [3:0] mstStbN = 4'hF;
    logic mstDrv = 1'b0;
    logic memWide = 1'b1;
    logic ioWide = 1'b1;
    logic dmaHoldOff, cpuReady, cpuDone, cpuConverted, slotDataOeN, slotAddr0;
    logic wideMemSelN, wideIoSelN;
    logic [15:0] cpuRdata, slotDataIn, slotDataOut;
    logic [3:0] pinN, seenN;
    wire logic [3:0] stbOutN;
    wire logic [3:0] stbOeN;
    int errors = 0;
    int totalChecks = 0;

    always #4 clk = ~clk;

    ssc_strobe_ctl #(.CMD_CYCLES(SSC_CNT_W'(CMD)), .RECOV_CYCLES(SSC_CNT_W'(RECOV))) u_dut (
        .clk(clk), .rst(rst), .hold_grant(hold_grant), .masterReqN(masterReqN),
        .dmaHoldOff(dmaHoldOff), .dmaStrobeN(dmaStrobeN), .cpuReq(cpuReq),
        .cpuWrite(cpuWrite), .cpuIo(cpuIo), .cpuWide(cpuWide), .cpuWdata(cpuWdata),
        .cpuReady(cpuReady), .cpuDone(cpuDone), .cpuConverted(cpuConverted),
        .cpuRdata(cpuRdata), .wide_mem_select_n(wideMemSelN), .wide_io_select_n(wideIoSelN),
        .ioReadStrobeNIn(pinN[0]), .ioReadStrobeNOut(stbOutN[0]), .ioReadStrobeOeN(stbOeN[0]),
        .ioWriteStrobeNIn(pinN[1]), .ioWriteStrobeNOut(stbOutN[1]),
        .ioWriteStrobeOeN(stbOeN[1]), .memReadStrobeNIn(pinN[2]),
        .memReadStrobeNOut(stbOutN[2]), .memReadStrobeOeN(stbOeN[2]),
        .memWriteStrobeNIn(pinN[3]), .memWriteStrobeNOut(stbOutN[3]),
        .memWriteStrobeOeN(stbOeN[3]), .busStrobeSeenN(seenN), .slotDataIn(slotDataIn),
        .slotDataOut(slotDataOut), .slotDataOeN(slotDataOeN), .slotAddr0(slotAddr0)
    );

    ssc_slot_model u_slot (
        .clk(clk), .stbOutN(stbOutN), .stbOeN(stbOeN), .addr0(slotAddr0),
        .mstStbN(mstStbN), .mstDrv(mstDrv), .memWide(memWide), .ioWide(ioWide),
        .pinN(pinN), .wideMemSelN(wideMemSelN), .wideIoSelN(wideIoSelN), .dataIn(slotDataIn)
    );

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    // Owner held two edges: seen level lags a pin handover by one; walking lanes
    task automatic run_direction();
        logic [3:0] dmaPat;
        logic [3:0] mstPat;
        logic own;
        for (int k = 0; k < 16; k++)
        begin
            @(negedge clk);
            dmaPat = ~(4'h1 << k[3:2]);
            mstPat = ~(4'h8 >> k[3:2]);
            own = k[1] & ~k[0];
            hold_grant = k[1];
            masterReqN = k[0];
            dmaStrobeN = dmaPat;
            mstStbN = mstPat;
            mstDrv = own;
            repeat (2) @(posedge clk);
            #1;
            check("pin enables", {12'h000, own ? 4'hF : 4'h0}, 16'(stbOeN));
            check("pin drive", {12'h000, (k[1] && k[0]) ? dmaPat : 4'hF}, 16'(stbOutN));
            check("seen strobes", {12'h000, own ? mstPat : (k[1] ? dmaPat : 4'hF)}, 16'(seenN));
            check("dma hold off", 16'(own), 16'(dmaHoldOff));
        end
        @(negedge clk);
        hold_grant = 1'b0;
        masterReqN = 1'b1;
        dmaStrobeN = 4'hF;
        mstDrv = 1'b0;
    endtask

    // One CPU cycle; sel high means the card leaves its wide select high
    task automatic run_cpu(input logic wr, input logic io, input logic wide, input logic sel);
        int lane;
        int falls;
        int n;
        logic conv;
        logic firstA0;
        logic prev;
        lane = io ? (wr ? SSC_STB_IOW : SSC_STB_IOR) : (wr ? SSC_STB_MEM_WRITE_STROBE_N : SSC_STB_MEM_READ_STROBE_N);
        conv = wide & sel;
        falls = 0;
        firstA0 = 1'b1;
        prev = 1'b1;
        n = 0;
        while (cpuReady !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 50)
        begin
            errors++;
            conclude();
        end
        @(negedge clk);
        memWide = ~sel;
        ioWide = ~sel;
        cpuWrite = wr;
        cpuIo = io;
        cpuWide = wide;
        cpuReq = 1'b1;
        @(negedge clk);
        cpuReq = 1'b0;
        n = 1;
        while (cpuDone !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
            if (prev && !stbOutN[lane])
            begin
                falls++;
                if (falls == 1)
                    firstA0 = slotAddr0;
            end
            prev = stbOutN[lane];
            check("idle lanes", 16'h000F, 16'(stbOutN | (4'h1 << lane)));
            if (wr && !stbOutN[lane])
                check("write byte", {8'h00, slotAddr0 ? 8'hC3 : 8'h96}, {8'h00, slotDataOut[7:0]});
            if (!stbOutN[lane])
                check("data drive", 16'(!wr), 16'(slotDataOeN));
        end
        if (n >= 100)
        begin
            errors++;
            conclude();
        end
        check("done edge", 16'(conv ? 2 * CMD + RECOV + 1 : CMD + 1), 16'(n));
        check("ready with done", 16'h0001, 16'(cpuReady));
        check("strobe count", 16'(conv ? 2 : 1), 16'(falls));
        check("first byte addr", 16'h0000, 16'(firstA0));
        check("converted flag", 16'(conv), 16'(cpuConverted));
        if (!wr)
            check("read word", wide ? 16'h3CA5 : 16'h00A5, cpuRdata);
    endtask

    // Grant held high: a CPU request must not start a cycle
    task automatic run_refused();
        @(negedge clk);
        hold_grant = 1'b1;
        cpuReq = 1'b1;
        dmaStrobeN = 4'hA;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            #1;
            check("done under grant", 16'h0000, 16'(cpuDone));
            check("dma drive", 16'h000A, 16'(stbOutN));
            check("ready under grant", 16'h0001, 16'(cpuReady));
        end
        @(negedge clk);
        cpuReq = 1'b0;
        hold_grant = 1'b0;
        dmaStrobeN = 4'hF;
        repeat (2) @(posedge clk);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (2) @(posedge clk);
        run_direction();
        for (int m = 0; m < 12; m++)
        begin
            run_cpu(m[0], m[1], m[3:2] != 2'b00, m[3:2] != 2'b10);
        end
        run_refused();
        run_cpu(1'b0, 1'b0, 1'b1, 1'b1);
        conclude();
    end
endmodule
